// ===== src/serial_rx_pkg.sv
// package: register map, field positions and state types for the serial receiver
package serial_rx_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_INTERRUPT_CONTROL   = 3'h0;
  localparam logic [2:0] ADDR_PERIPH_IRQ_ENABLE   = 3'h1;
  localparam logic [2:0] ADDR_PERIPH_IRQ_FLAGS    = 3'h2;
  localparam logic [2:0] ADDR_RECEIVE_CTRL_STATUS = 3'h3;
  localparam logic [2:0] ADDR_RECEIVE_DATA        = 3'h4;
  localparam logic [2:0] ADDR_TRANSMIT_CTRL_STAT  = 3'h5;
  localparam logic [2:0] ADDR_SEGMENT_ENABLE      = 3'h6;

  // interrupt_control fields
  localparam int GLOBAL_IRQ_EN_BIT = 7;
  localparam int PERIPH_IRQ_EN_BIT = 6;
  // peripheral enable / flag fields
  localparam int RECEIVE_IRQ_EN_BIT = 5;
  localparam int RECEIVE_FLAG_BIT   = 5;
  // receive_control_status fields
  localparam int SERIAL_PORT_ON_BIT  = 7;
  localparam int NINE_BIT_SEL_BIT    = 6;
  localparam int CONT_RECEIVE_EN_BIT = 4;
  localparam int FRAMING_ERR_BIT     = 2;
  localparam int OVERRUN_ERR_BIT     = 1;
  localparam int NINTH_BIT_BIT       = 0;
  // transmit_control_status fields
  localparam int CLOCKED_MODE_BIT    = 4;
  localparam logic [7:0] TX_STATUS_RESET = 8'h02;
  // segment enable field for the receive pin
  localparam int SEGMENT_EIGHT_BIT   = 0;

  // oversampling figures, in baud ticks
  localparam logic [3:0] TICKS_PER_BIT  = 4'hf;
  localparam logic [3:0] HALF_BIT_TICKS = 4'h7;
  // the bit counter restarts at the verified start centre, so the centre of every
  // later bit falls on the last tick of each count; two votes sit just before it, the third on it
  localparam logic [3:0] VOTE_A_TICK    = 4'hd;
  localparam logic [3:0] VOTE_B_TICK    = 4'he;
  localparam logic [3:0] VOTE_C_TICK    = 4'hf;
  localparam logic [3:0] DATA_BITS_8    = 4'h8;
  localparam logic [3:0] DATA_BITS_9    = 4'h9;
  localparam int FIFO_DEPTH = 2;

  typedef enum {ST_IDLE, ST_START, ST_DATA, ST_STOP} rx_state_t;

  typedef struct packed {
    logic [8:0] data;
    logic       framing_err;
  } fifo_entry_t;

  typedef struct packed {
    rx_state_t   state;
    logic [3:0]  tick_cnt;
    logic [3:0]  bit_cnt;
    logic [2:0]  votes;
    logic [8:0]  shift;
    logic        line_prev;
    fifo_entry_t entry0;
    fifo_entry_t entry1;
    logic [1:0]  count;
    logic        overrun;
    logic [7:0]  interrupt_control;
    logic [7:0]  pie;
    logic [7:0]  receive_control_status;
    logic [7:0]  transmit_control_status;
    logic [7:0]  segen;
    logic [7:0]  rdata;
  } rx_regs_t;
endpackage

// ===== src/serial_rx.sv
// serial receiver: oversampled start detect, shift, two-entry fifo, register port
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ns
// Notes on behaviour
// - line sampled at sixteen ticks per bit; shifter moves once per bit
// - finished 8 or 9 bit character goes at once into two-deep fifo
// - two full characters plus start of a third accepted before servicing
// - shifter and fifo unreachable; data only via receive data register reads
// - reception active only with receive enable, async mode, port on
// - port on forces the receive pin to input
// - port on drives the transmit pin as output, port latch disconnected
// - a falling edge while idle starts a character
// - half bit later line must still be low, else silent abort
// - full bit steps to each centre, majority vote, shift in
// - stop bit sampled; low sets framing error, high clears it
// - after stop bit character pushed to fifo and receive flag raised
// - receive data read returns oldest entry and pops it
// - after overrun no characters accepted until it is cleared
// - receive flag equals enabled and fifo not empty; not writable
// - interrupt only with all three enables and the receive flag
// - receive flag independent of interrupt enables
// - least significant bit arrives first
// - nine bit mode shifts nine bits, ninth shown as top entry msb
// - each fifo entry has its own framing error; top entry shown
// - overrun sets on third character with fifo full; cleared by receive enable off
module serial_rx
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // oversampling tick from rate generator
  input  wire logic       baud_tick,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // pins
  input  wire logic       receive_pin_in,
  output logic            receive_pin_oe,
  input  wire logic       transmit_data_in,
  input  wire logic       port_latch_tx,
  input  wire logic       pin_direction_tx,
  output logic            transmit_pin_out,
  output logic            transmit_pin_oe,
  // interrupt request
  output logic            receive_irq
);

  serial_rx_pkg::rx_regs_t r_reg;
  serial_rx_pkg::rx_regs_t r_next;

  logic rx_active;
  logic port_on;
  logic flag;
  logic pop;
  logic vote;
  logic [3:0] nbits;

  // 2 of 3 majority of the centre samples
  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction

  always_comb
  begin
    port_on   = r_reg.receive_control_status[serial_rx_pkg::SERIAL_PORT_ON_BIT];
    rx_active = r_reg.receive_control_status[serial_rx_pkg::CONT_RECEIVE_EN_BIT] & port_on
              & ~r_reg.transmit_control_status[serial_rx_pkg::CLOCKED_MODE_BIT];
    flag      = rx_active & (r_reg.count != 2'h0);
    pop       = reg_read & (reg_addr == serial_rx_pkg::ADDR_RECEIVE_DATA)
              & (r_reg.count != 2'h0);
    nbits     = r_reg.receive_control_status[serial_rx_pkg::NINE_BIT_SEL_BIT] ? serial_rx_pkg::DATA_BITS_9
                                                            : serial_rx_pkg::DATA_BITS_8;
    // the third vote is the live line in the deciding tick itself
    vote      = majority({receive_pin_in, r_reg.votes[1:0]});
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    serial_rx_pkg::fifo_entry_t pushed;
    logic [1:0]                 fill;
    pushed = '0;
    fill   = 2'h0;
    r_next = r_reg;
    // the edge detector compares tick samples only: the line may fall anywhere
    // between two ticks, and a copy refreshed every cycle would already hold the
    // low level by the time the next tick looks at it
    if (baud_tick)
    begin
      r_next.line_prev = receive_pin_in;
    end

    // ****************************************
    // register writes; flag and status bits are not writable
    // ****************************************
    if (reg_write)
    begin
      unique case (reg_addr)
        serial_rx_pkg::ADDR_INTERRUPT_CONTROL: r_next.interrupt_control = reg_wdata;
        serial_rx_pkg::ADDR_PERIPH_IRQ_ENABLE: r_next.pie = reg_wdata;
        serial_rx_pkg::ADDR_RECEIVE_CTRL_STATUS:
        begin
          // error and ninth bit fields are hardware owned
          r_next.receive_control_status = {reg_wdata[7:3], r_reg.receive_control_status[2:0]};
        end
        serial_rx_pkg::ADDR_TRANSMIT_CTRL_STAT:
        begin
          r_next.transmit_control_status = {reg_wdata[7:2], r_reg.transmit_control_status[1], reg_wdata[0]};
        end
        serial_rx_pkg::ADDR_SEGMENT_ENABLE: r_next.segen = reg_wdata;
        default: ;
      endcase
    end

    // read pops the oldest entry
    if (pop)
    begin
      r_next.entry0 = r_reg.entry1;
      r_next.count  = r_reg.count - 2'h1;
    end

    // ****************************************
    // receive engine, advanced only on baud ticks
    // ****************************************
    if (!rx_active)
    begin
      r_next.state = serial_rx_pkg::ST_IDLE;
    end
    else if (baud_tick)
    begin
      r_next.tick_cnt = r_reg.tick_cnt + 4'h1;
      // two votes are stored ahead of the centre; the centre sample itself is
      // used live, so one noisy tick cannot flip a bit
      unique case (r_reg.tick_cnt)
        serial_rx_pkg::VOTE_A_TICK:
        begin
          r_next.votes[0] = receive_pin_in;
        end
        serial_rx_pkg::VOTE_B_TICK:
        begin
          r_next.votes[1] = receive_pin_in;
        end
        serial_rx_pkg::VOTE_C_TICK:
        begin
          r_next.votes[2] = receive_pin_in;
        end
        default:
        begin
        end
      endcase
      unique case (r_reg.state)
        serial_rx_pkg::ST_IDLE:
        begin
          r_next.tick_cnt = 4'h0;
          // overrun holds off new characters
          if (r_reg.line_prev & ~receive_pin_in & ~r_reg.overrun)
          begin
            r_next.state = serial_rx_pkg::ST_START;
          end
        end
        serial_rx_pkg::ST_START:
        begin
          if (r_reg.tick_cnt == serial_rx_pkg::HALF_BIT_TICKS)
          begin
            r_next.tick_cnt = 4'h0;
            r_next.bit_cnt  = 4'h0;
            // a glitch is dropped without any error
            r_next.state = receive_pin_in ? serial_rx_pkg::ST_IDLE
                                          : serial_rx_pkg::ST_DATA;
          end
        end
        serial_rx_pkg::ST_DATA:
        begin
          // votes lead up to the bit centre; decision taken on the centre tick itself
          if (r_reg.tick_cnt == serial_rx_pkg::TICKS_PER_BIT)
          begin
            // lsb first: shift right, new bit enters at the top
            r_next.shift   = {vote, r_reg.shift[8:1]};
            r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
            if (r_reg.bit_cnt + 4'h1 == nbits)
              r_next.state = serial_rx_pkg::ST_STOP;
          end
        end
        serial_rx_pkg::ST_STOP:
        begin
          if (r_reg.tick_cnt == serial_rx_pkg::TICKS_PER_BIT)
          begin
            // eight bit characters sit one place high in the shifter
            if (r_reg.receive_control_status[serial_rx_pkg::NINE_BIT_SEL_BIT])
            begin
              pushed.data = r_reg.shift;
            end
            else
            begin
              pushed.data = {1'b0, r_reg.shift[8:1]};
            end
            // a low stop sample marks this character only
            pushed.framing_err = ~vote;
            // a read in this same cycle has already freed its slot
            fill = r_next.count;
            // push a finished character; full fifo raises overrun instead
            if (fill == 2'(serial_rx_pkg::FIFO_DEPTH))
            begin
              // the character is lost; stored ones stay readable
              r_next.overrun = 1'b1;
            end
            else if (fill == 2'h0)
            begin
              r_next.entry0 = pushed;
              r_next.count  = 2'h1;
            end
            else
            begin
              r_next.entry1 = pushed;
              r_next.count  = 2'h2;
            end
            r_next.state = serial_rx_pkg::ST_IDLE;
          end
        end
      endcase
    end

    // clearing receive enable clears overrun
    if (!r_reg.receive_control_status[serial_rx_pkg::CONT_RECEIVE_EN_BIT])
      r_next.overrun = 1'b0;
    // port off resets the fifo and framing status
    if (!port_on)
      r_next.count = 2'h0;

    // visible status tracks the top unread entry, except overrun, which mirrors the overrun flag
    r_next.receive_control_status[serial_rx_pkg::FRAMING_ERR_BIT] =
      (r_next.count != 2'h0) & r_next.entry0.framing_err;
    r_next.receive_control_status[serial_rx_pkg::NINTH_BIT_BIT] = r_next.entry0.data[8];
    r_next.receive_control_status[serial_rx_pkg::OVERRUN_ERR_BIT] = r_next.overrun;

    // ****************************************
    // read data, one cycle after the strobe
    // ****************************************
    r_next.rdata = 8'h00;
    if (reg_read)
    begin
      unique case (reg_addr)
        serial_rx_pkg::ADDR_INTERRUPT_CONTROL: r_next.rdata = r_reg.interrupt_control;
        serial_rx_pkg::ADDR_PERIPH_IRQ_ENABLE: r_next.rdata = r_reg.pie;
        serial_rx_pkg::ADDR_PERIPH_IRQ_FLAGS:
          r_next.rdata = 8'(flag) << serial_rx_pkg::RECEIVE_FLAG_BIT;
        serial_rx_pkg::ADDR_RECEIVE_CTRL_STATUS: r_next.rdata = r_reg.receive_control_status;
        serial_rx_pkg::ADDR_RECEIVE_DATA: r_next.rdata = r_reg.entry0.data[7:0];
        serial_rx_pkg::ADDR_TRANSMIT_CTRL_STAT: r_next.rdata = r_reg.transmit_control_status;
        serial_rx_pkg::ADDR_SEGMENT_ENABLE: r_next.rdata = r_reg.segen;
        default: r_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      r_reg       <= '0;
      r_reg.state <= serial_rx_pkg::ST_IDLE;
      r_reg.transmit_control_status <= serial_rx_pkg::TX_STATUS_RESET;
      r_reg.line_prev <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb
  begin
    reg_rdata        = r_reg.rdata;
    receive_pin_oe   = ~port_on & ~r_reg.segen[serial_rx_pkg::SEGMENT_EIGHT_BIT]
                     & 1'b0;
    // port on: serial driver owns the pin regardless of direction bit
    transmit_pin_oe  = port_on | ~pin_direction_tx;
    transmit_pin_out = port_on ? transmit_data_in : port_latch_tx;
    receive_irq      = flag & r_reg.pie[serial_rx_pkg::RECEIVE_IRQ_EN_BIT]
                     & r_reg.interrupt_control[serial_rx_pkg::PERIPH_IRQ_EN_BIT]
                     & r_reg.interrupt_control[serial_rx_pkg::GLOBAL_IRQ_EN_BIT];
  end

endmodule

// ===== test/serial_rx_asserts.sv
// port assertions for the serial receiver
`timescale 1ns/1ns
module serial_rx_asserts
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // watched ports
  input wire logic       baud_tick,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       receive_pin_in,
  input wire logic       receive_pin_oe,
  input wire logic       transmit_data_in,
  input wire logic       port_latch_tx,
  input wire logic       pin_direction_tx,
  input wire logic       transmit_pin_out,
  input wire logic       transmit_pin_oe,
  input wire logic       receive_irq
);
  // ******************************
  // shadows rebuilt from writes
  // ******************************
  logic [7:0] sh_reg [8];
  logic [7:0] high_reg;
  logic       en;
  logic       irq_en;
  assign en = sh_reg[3][7] & sh_reg[3][4] & ~sh_reg[5][4];
  assign irq_en = sh_reg[0][7] & sh_reg[0][6] & sh_reg[1][5];
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      for (int i = 0; i < 8; i++) sh_reg[i] <= 8'h00;
    else if (reg_write)
      sh_reg[reg_addr] <= reg_wdata;
  end
  // ticks the line has stayed high, saturating
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !receive_pin_in)
      high_reg <= 8'h00;
    else if (baud_tick && high_reg != 8'hff)
      high_reg <= high_reg + 8'h01;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_new_char;
    $rose(receive_irq) && $past(en) && $past(irq_en);
  endsequence
  a_rdata_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data outside answer cycle");
  a_rx_pin_in: assert property (
    sh_reg[3][7] |-> !receive_pin_oe) else $error("receive pin driven");
  a_tx_port_on: assert property (
    sh_reg[3][7] |-> transmit_pin_oe && transmit_pin_out == transmit_data_in)
    else $error("transmit pin not serial output");
  a_tx_port_off: assert property (
    !sh_reg[3][7] |-> transmit_pin_oe == !pin_direction_tx && transmit_pin_out == port_latch_tx)
    else $error("transmit pin not general port");
  a_irq_enables: assert property (
    receive_irq |-> irq_en) else $error("interrupt without all enables");
  a_irq_rx_off: assert property (
    !en && !$past(en) |-> !receive_irq) else $error("interrupt with receiver off");
  a_start_needed: assert property (
    s_new_char |-> high_reg < 8'd200) else $error("character without a start bit");
  a_char_on_tick: assert property (
    s_new_char |-> $past(baud_tick)) else $error("character pushed off a tick");
endmodule
bind serial_rx serial_rx_asserts i_serial_rx_asserts (.*);

// ===== test/tx_model.sv
// remote asynchronous transmitter on the receive line
`timescale 1ns/1ns
module tx_model
(
  // clock and tick
  input wire logic clk_sys,
  input wire logic baud_tick,
  // serial line, idle mark
  output logic     line
);
  // ******************************
  // frame generation
  // ******************************
  initial line = 1'b1;
  task automatic wt(input int n);
    repeat (n) do @(posedge clk_sys); while (baud_tick !== 1'b1);
  endtask
  task automatic send(input logic [8:0] d, input int nb, input logic stop_lvl);
    line <= 1'b0;
    wt(16);
    for (int i = 0; i < nb; i++)
    begin
      line <= d[i];
      wt(16);
    end
    line <= stop_lvl;
    wt(16);
    line <= 1'b1;
    wt(4);
  endtask
  // low pulse shorter than half a bit
  task automatic glitch();
    line <= 1'b0;
    wt(4);
    line <= 1'b1;
    wt(40);
  endtask
endmodule

// ===== test/async_serial_receiver_test.sv
// self-checking bench for the serial receiver
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end
module async_serial_receiver_test;
  // ******************************
  // stimulus and queue model
  // ******************************
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       baud_tick = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic       transmit_data_in = 1'b0;
  logic       port_latch_tx = 1'b0;
  logic       pin_direction_tx = 1'b1;
  logic [7:0] reg_rdata;
  logic       receive_pin_in, receive_pin_oe, transmit_pin_out, transmit_pin_oe, receive_irq;
  logic [1:0] div = 2'h0;
  logic [7:0] v;
  logic [9:0] q[$];
  int         fail_count = 0;
  int         checks = 0;
  int         cyc = 0;
  bit         ovr = 0;
  bit         en_m = 0;
  serial_rx i_serial_rx (
    .clk_sys          (clk_sys),
    .sys_rst          (sys_rst),
    .baud_tick        (baud_tick),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_write        (reg_write),
    .reg_read         (reg_read),
    .reg_rdata        (reg_rdata),
    .receive_pin_in   (receive_pin_in),
    .receive_pin_oe   (receive_pin_oe),
    .transmit_data_in (transmit_data_in),
    .port_latch_tx    (port_latch_tx),
    .pin_direction_tx (pin_direction_tx),
    .transmit_pin_out (transmit_pin_out),
    .transmit_pin_oe  (transmit_pin_oe),
    .receive_irq      (receive_irq)
  );
  tx_model i_tx_model (.clk_sys(clk_sys), .baud_tick(baud_tick), .line(receive_pin_in));
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    div <= div + 2'h1;
    baud_tick <= (div == 2'h3);
    {transmit_data_in, port_latch_tx, pin_direction_tx} <= 3'($urandom);
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // a full queue turns the next character into an overrun, not an entry
  task automatic rx(input logic [8:0] d, input int nb, input logic stop_lvl);
    i_tx_model.send(d, nb, stop_lvl);
    if (nb == 8) d[8] = 1'b0;
    if (en_m && !ovr)
    begin
      if (q.size() == 2) ovr = 1;
      else q.push_back({!stop_lvl, d});
    end
  endtask
  task automatic take();
    rd(3);
    `CHK("framing", q[0][9], v[2])
    `CHK("ninth", q[0][8], v[0])
    `CHK("overrun", ovr, v[1])
    rd(4);
    `CHK("data", q[0][7:0], v)
    void'(q.pop_front());
  endtask
  task automatic flagchk(input logic f, input logic irq);
    rd(2);
    `CHK("flag", f, v[5])
    `CHK("irq", irq, receive_irq)
  endtask
  initial
  begin
    void'($urandom(77829));
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(5);
    `CHK("tx status", serial_rx_pkg::TX_STATUS_RESET, v)
    rd(7);
    `CHK("unmapped", 8'h00, v)
    wr(2, 8'hff);
    rd(2);
    `CHK("flag write", 8'h00, v)
    wr(6, 8'h00);
    wr(3, 8'h90);
    wr(1, 8'h20);
    wr(0, 8'hc0);
    en_m = 1;
    repeat (3)
    begin
      rx(9'($urandom), 8, 1'b1);
      flagchk(1'b1, 1'b1);
      take();
      flagchk(1'b0, 1'b0);
    end
    rx(9'h0a5, 8, 1'b1);
    wr(0, 8'h80);
    flagchk(1'b1, 1'b0);
    wr(0, 8'hc0);
    take();
    i_tx_model.glitch();
    flagchk(1'b0, 1'b0);
    rx(9'($urandom), 8, 1'b0);
    rx(9'($urandom), 8, 1'b1);
    rx(9'($urandom), 8, 1'b1);
    rx(9'h055, 8, 1'b1);
    take();
    take();
    flagchk(1'b0, 1'b0);
    wr(3, 8'h80);
    ovr = 0;
    rd(3);
    `CHK("overrun clear", 1'b0, v[1])
    wr(5, 8'h10);
    wr(3, 8'h90);
    en_m = 0;
    rx(9'h1c3, 8, 1'b1);
    flagchk(1'b0, 1'b0);
    wr(5, 8'h00);
    wr(3, 8'hd0);
    en_m = 1;
    rx(9'($urandom), 9, 1'b1);
    rx(9'($urandom), 9, 1'b1);
    take();
    take();
    wr(3, 8'h00);
    flagchk(1'b0, 1'b0);
    complete_run();
  end
endmodule
